/* common/gpio_map_consts.svh */
`ifndef GPIO_MAP_CONSTS_SVH
`define GPIO_MAP_CONSTS_SVH
// register byte addresses on the wishbone slave
`define ADDR_PIN_CONFIG   8'h00
`define ADDR_SW_TRIGGER   8'h04
`define ADDR_IRQ_STATUS   8'h08
`define ADDR_IRQ_MASK     8'h0C
`define ADDR_PIN_STATE    8'h10
// pin configuration field positions
`define CFG_INPUT_EN_BIT  0
`define CFG_IN_CODE_LSB   1
`define CFG_CH_SEL_LSB    5
`define CFG_OUT_CODE_LSB  9
`define CFG_OUTPUT_EN_BIT 13
`define CFG_RESET_VALUE   14'h0000
// cycles the boot waits for the pin chain to hold the real level
`define BOOT_SETTLE       2'h3
// input function codes
`define IN_FAULT_DUMP     4'h2
`define IN_CURRENT_OUTPUT_PWR       4'h3
`define IN_VOLTAGE_OUTPUT_PWR       4'h4
`define IN_PROTECT        4'h5
`define IN_CLEAR          4'h7
`define IN_LOAD           4'h8
`define IN_FUNC_GEN       4'h9
`define IN_MARGIN         4'hA
`define IN_RESET          4'hB
`define IN_NVM_LOCK       4'hC
`define IN_REG_LOCK       4'hD
// output status codes
`define OUT_NONVOLATILE_BUSY_FLAG      4'h1
`define OUT_CH1_BUSY      4'h4
`define OUT_CH0_BUSY      4'h7
`define OUT_WIN_CMP1      4'h8
`define OUT_WIN_CMP0      4'hB
`endif

/* common/gpio_map_pkg.sv */
package gpio_map_pkg;
    // per-channel trigger pulses towards the converter core
    typedef struct packed {
        logic [1:0] current_output_down;
        logic [1:0] current_output_up;
        logic [1:0] voltage_output_down;
        logic [1:0] voltage_output_up;
        logic [1:0] load;
        logic [1:0] gen_stop;
        logic [1:0] gen_start;
        logic [1:0] margin_low;
        logic [1:0] margin_high;
    } chan_trig_s;
    // global trigger pulses
    typedef struct packed {
        logic fault_dump;
        logic protect;
        logic clear;
        logic dev_reset;
    } glob_trig_s;
    // status inputs the pin can present
    typedef struct packed {
        logic nonvolatile_busy_flag;
        logic ch1_busy;
        logic ch0_busy;
        logic window_compare_ch1;
        logic window_compare_ch0;
    } status_s;
    typedef enum logic [1:0] {
        BOOT_WAIT = 2'b00,
        BOOT_FIRE = 2'b01,
        RUN       = 2'b10
    } boot_e;
endpackage : gpio_map_pkg

/* logic/gpio_function_mapper.sv */
// How it works
// (RQ1) input-enable bit makes the pin an input
// (RQ2) output-enable bit makes the pin drive output
// (RQ3) channel functions act only on selected channels
// (RQ4) level sampled once at boot, then edges
// (RQ5) default mapping is none: no trigger, no status
// (RQ6) mapped input function masks matching software trigger
// (RQ7) code 1011 low pulse resets, rising ignored
// (RQ8) register constraints also gate pin triggers; the write lock here gates only the software clear, a pin clear alone passes
// (RQ9) codes 0010/0101/0111 fire on falling only
// (RQ10) code 0100 voltage outputs down/up by edge
// (RQ11) codes 0011/1001/1010 current, generator, margin edges
// (RQ12) code 1000 falling loads sync-configured selected channels
// (RQ13) code 1100 nvm permit/block, 1101 falling permits writes
// (RQ14) after 1101 rising, writes locked except unlock/reset
// (RQ15) board ties unused pin; reset config kept nonvolatile
// (RQ16) output presents status chosen by output code
// (RQ17) pin synchronised, edges from synchronised samples
`timescale 1ns/1ps
`default_nettype none
`include "gpio_map_consts.svh"
module gpio_function_mapper (
    input  wire logic                      core_clk_i,
    input  wire logic                      rst_i,
    // wishbone classic slave
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [7:0]                wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    // the general-purpose pin
    input  wire logic                      pin_i,
    output logic                           pin_o,
    output logic                           pin_oe_n_o,
    // converter side
    input  wire logic [1:0]                sync_config_i,
    input  wire logic                      reg_write_i,
    input  wire logic                      reg_write_exempt_i,
    input  wire gpio_map_pkg::status_s     status_i,
    output gpio_map_pkg::chan_trig_s       chan_trig_o,
    output gpio_map_pkg::glob_trig_s       glob_trig_o,
    output logic                           nvm_prog_allowed_o,
    output logic                           reg_write_allowed_o,
    output logic                           reg_write_reject_o,
    output logic                           irq_o
);
    import gpio_map_pkg::*;

    // configuration and software trigger registers
    logic [13:0] cfg;            // pin configuration
    logic [13:0] next_cfg;
    logic [3:0]  sw_trig;        // software global triggers, one-cycle pulses
    logic [3:0]  next_sw_trig;
    logic [2:0]  irq_status;     // sticky: boot, fall, rise seen
    logic [2:0]  next_irq_status;
    logic [2:0]  irq_mask;
    logic [2:0]  next_irq_mask;
    logic [31:0] next_dat;
    logic        next_ack;

    // pin sampling chain
    logic [2:0]  pin_sync;       // three stages from the pin
    logic        pin_level;      // debounced level: stage two and three agree
    logic        next_pin_level;
    boot_e       boot;
    boot_e       next_boot;
    logic [1:0]  settle;         // cycles spent filling the pin chain
    logic [1:0]  next_settle;

    // outputs computed combinationally, then registered
    chan_trig_s  next_chan;
    glob_trig_s  next_glob;
    logic        next_pin_o;
    logic        next_oe_n;
    logic        nvm_ok;
    logic        next_nvm_ok;
    logic        reg_ok;
    logic        next_reg_ok;
    logic        next_reject;
    logic        next_irq;

    // decoded configuration fields
    logic        in_en;
    logic        out_en;
    logic [3:0]  in_code;
    logic [3:0]  out_code;
    logic [1:0]  ch_sel;
    logic        fall;
    logic        rise;
    logic        sample_now;
    logic        bus_wr;
    logic        bus_rd;

    assign in_en    = cfg[`CFG_INPUT_EN_BIT];
    assign out_en   = cfg[`CFG_OUTPUT_EN_BIT];
    assign in_code  = cfg[`CFG_IN_CODE_LSB +: 4];
    assign ch_sel   = cfg[`CFG_CH_SEL_LSB +: 2];
    assign out_code = cfg[`CFG_OUT_CODE_LSB +: 4];
    // single-cycle answer: ack is dropped the cycle after it was given
    assign bus_wr   = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
    assign bus_rd   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;

    // edges come only from the agreed, synchronised level
    always_comb begin
        next_pin_level = pin_level;
        if (pin_sync[1] == pin_sync[2]) begin // RQ17
            next_pin_level = pin_sync[2];
        end
        fall = pin_level && !next_pin_level;  // RQ17
        rise = !pin_level && next_pin_level;  // RQ17
    end

    // boot: wait until the chain holds the real pin level, then act once on it;
    // acting earlier would read the reset value and fake an edge afterwards
    always_comb begin
        next_boot   = boot;
        next_settle = settle;
        sample_now  = 1'b0;
        case (boot)
            BOOT_WAIT: begin
                if (settle == `BOOT_SETTLE) begin
                    next_boot = BOOT_FIRE;
                end else begin
                    next_settle = 2'(settle + 2'h1);
                end
            end
            BOOT_FIRE: begin
                sample_now = 1'b1;            // RQ4
                next_boot  = RUN;
            end
            RUN:       next_boot = RUN;
            default:   next_boot = BOOT_WAIT;
        endcase
    end

    // function dispatch from pin edges, boot level and software
    always_comb begin
        logic act_fall;
        logic act_rise;
        logic [1:0] sel;
        logic       pin_in;
        act_fall  = 1'b0;
        act_rise  = 1'b0;
        sel       = ch_sel;                   // RQ3
        pin_in    = in_en && !out_en;         // RQ1
        next_chan = '0;
        next_glob = '0;
        next_nvm_ok = nvm_ok;
        next_reg_ok = reg_ok;
        if (pin_in) begin
            // at boot the level stands in for the edge that would give it
            act_fall = (boot == RUN) ? fall : (sample_now && !pin_level); // RQ4
            act_rise = (boot == RUN) ? rise : (sample_now && pin_level);  // RQ4
        end
        case (pin_in ? in_code : 4'h0)        // RQ5
            `IN_FAULT_DUMP: next_glob.fault_dump = act_fall; // RQ9
            `IN_PROTECT:    next_glob.protect    = act_fall; // RQ9
            `IN_CLEAR:      next_glob.clear      = act_fall; // RQ9
            `IN_RESET:      next_glob.dev_reset  = act_fall; // RQ7
            `IN_CURRENT_OUTPUT_PWR: begin                              // RQ11
                next_chan.current_output_down = act_fall ? sel : 2'b00;
                next_chan.current_output_up   = act_rise ? sel : 2'b00;
            end
            `IN_VOLTAGE_OUTPUT_PWR: begin                              // RQ10
                next_chan.voltage_output_down = act_fall ? sel : 2'b00;
                next_chan.voltage_output_up   = act_rise ? sel : 2'b00;
            end
            `IN_LOAD: next_chan.load = act_fall ? (sel & sync_config_i) : 2'b00; // RQ8 RQ12
            `IN_FUNC_GEN: begin                              // RQ11
                next_chan.gen_stop  = act_fall ? sel : 2'b00;
                next_chan.gen_start = act_rise ? sel : 2'b00;
            end
            `IN_MARGIN: begin                                // RQ11
                next_chan.margin_low  = act_fall ? sel : 2'b00;
                next_chan.margin_high = act_rise ? sel : 2'b00;
            end
            `IN_NVM_LOCK: begin                              // RQ13
                if (act_fall) next_nvm_ok = 1'b1;
                if (act_rise) next_nvm_ok = 1'b0;
            end
            `IN_REG_LOCK: begin
                if (act_fall) next_reg_ok = 1'b1;            // RQ13
                if (act_rise) next_reg_ok = 1'b0;            // RQ14
            end
            default: ;
        endcase
        // software triggers pass only when the pin does not own the function
        if (!(pin_in && in_code == `IN_FAULT_DUMP)) next_glob.fault_dump |= sw_trig[0]; // RQ6
        if (!(pin_in && in_code == `IN_PROTECT))    next_glob.protect    |= sw_trig[1]; // RQ6
        if (!(pin_in && in_code == `IN_CLEAR))      next_glob.clear      |= sw_trig[2]; // RQ6
        if (!(pin_in && in_code == `IN_RESET))      next_glob.dev_reset  |= sw_trig[3]; // RQ6
        // while writes are locked a software clear pulse suppresses the clear trigger; a pin clear alone passes
        if (!reg_ok) next_glob.clear = next_glob.clear & !sw_trig[2];  // RQ8
        next_reject = reg_write_i && !reg_ok && !reg_write_exempt_i;   // RQ14
    end

    // output status mux; unknown codes drive low
    always_comb begin
        logic st;
        st = 1'b0;
        case (out_code)                                              // RQ16
            `OUT_NONVOLATILE_BUSY_FLAG: st = status_i.nonvolatile_busy_flag;
            `OUT_CH1_BUSY: st = status_i.ch1_busy;
            `OUT_CH0_BUSY: st = status_i.ch0_busy;
            `OUT_WIN_CMP1: st = status_i.window_compare_ch1;
            `OUT_WIN_CMP0: st = status_i.window_compare_ch0;
            default:       st = 1'b0;                                // RQ5
        endcase
        next_pin_o = out_en && st;                                   // RQ2
        next_oe_n  = !out_en;                                        // RQ2
    end

    // register file, interrupts and bus answer
    always_comb begin
        logic [2:0] ev;
        // pin edges count only once boot is over and the input-enable bit is set, even while the output-enable bit is set too
        ev = {rise && in_en && boot == RUN, fall && in_en && boot == RUN, sample_now};
        next_cfg     = cfg;
        next_sw_trig = 4'h0;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        next_dat = 32'h0000_0000;
        next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
        if (bus_wr && wb_sel_i[0]) begin
            case (wb_adr_i)
                `ADDR_SW_TRIGGER: next_sw_trig = wb_dat_i[3:0];
                `ADDR_IRQ_STATUS: next_irq_status = irq_status & ~wb_dat_i[2:0];
                `ADDR_IRQ_MASK:   next_irq_mask = wb_dat_i[2:0];
                `ADDR_PIN_CONFIG: next_cfg[7:0] = wb_dat_i[7:0];
                default: ;
            endcase
        end
        if (bus_wr && wb_sel_i[1] && wb_adr_i == `ADDR_PIN_CONFIG) begin
            next_cfg[13:8] = wb_dat_i[13:8];
        end
        next_irq_status = next_irq_status | ev;   // set wins over clear
        if (bus_rd) begin
            case (wb_adr_i)
                `ADDR_PIN_CONFIG: next_dat = {18'h00000, cfg};
                `ADDR_IRQ_STATUS: next_dat = {29'h0, irq_status};
                `ADDR_IRQ_MASK:   next_dat = {29'h0, irq_mask};
                `ADDR_PIN_STATE:  next_dat = {29'h0, reg_ok, nvm_ok, pin_level};
                default:          next_dat = 32'h0000_0000;
            endcase
        end
        next_irq = |(next_irq_status & next_irq_mask);
    end

    // all state registered here
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg        <= `CFG_RESET_VALUE;
            sw_trig    <= 4'h0;
            irq_status <= 3'h0;
            irq_mask   <= 3'h0;
            pin_sync   <= 3'h0;
            pin_level  <= 1'b0;
            boot       <= BOOT_WAIT;
            settle     <= 2'h0;
            chan_trig_o <= '0;
            glob_trig_o <= '0;
            nvm_ok     <= 1'b0;
            reg_ok     <= 1'b1;
            pin_o      <= 1'b0;
            pin_oe_n_o <= 1'b1;
            wb_dat_o   <= 32'h0000_0000;
            wb_ack_o   <= 1'b0;
            irq_o      <= 1'b0;
            nvm_prog_allowed_o  <= 1'b0;
            reg_write_allowed_o <= 1'b1;
            reg_write_reject_o  <= 1'b0;
        end else begin
            cfg        <= next_cfg;
            sw_trig    <= next_sw_trig;
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
            pin_sync   <= {pin_sync[1:0], pin_i};
            pin_level  <= next_pin_level;
            boot       <= next_boot;
            settle     <= next_settle;
            chan_trig_o <= next_chan;
            glob_trig_o <= next_glob;
            nvm_ok     <= next_nvm_ok;
            reg_ok     <= next_reg_ok;
            pin_o      <= next_pin_o;
            pin_oe_n_o <= next_oe_n;
            wb_dat_o   <= next_dat;
            wb_ack_o   <= next_ack;
            irq_o      <= next_irq;
            nvm_prog_allowed_o  <= next_nvm_ok;
            reg_write_allowed_o <= next_reg_ok;
            reg_write_reject_o  <= next_reject;
        end
    end

    // checks
    a_fault_on_fall: assert property (@(posedge core_clk_i) disable iff (rst_i) // RQ9
        (boot == RUN && in_en && !out_en && in_code == `IN_FAULT_DUMP && fall)
        |=> glob_trig_o.fault_dump) else $error("fault dump missed");
    a_no_fault_rise: assert property (@(posedge core_clk_i) disable iff (rst_i) // RQ9
        (boot == RUN && in_code == `IN_FAULT_DUMP && rise && sw_trig == 4'h0)
        |=> !glob_trig_o.fault_dump) else $error("fault dump on rise");
    a_reset_low: assert property (@(posedge core_clk_i) disable iff (rst_i) // RQ7
        (boot == RUN && in_en && !out_en && in_code == `IN_RESET && rise)
        |=> !glob_trig_o.dev_reset) else $error("reset on rising edge");
    a_voltage_output_sel: assert property (@(posedge core_clk_i) disable iff (rst_i) // RQ10
        (boot == RUN && in_en && !out_en && in_code == `IN_VOLTAGE_OUTPUT_PWR && fall)
        |=> chan_trig_o.voltage_output_down == $past(ch_sel)) else $error("voltage_output channels wrong");
    a_margin_hi: assert property (@(posedge core_clk_i) disable iff (rst_i) // RQ11
        (boot == RUN && in_en && !out_en && in_code == `IN_MARGIN && rise)
        |=> chan_trig_o.margin_high == $past(ch_sel)) else $error("margin high wrong");
    a_load_sync: assert property (@(posedge core_clk_i) disable iff (rst_i) // RQ12
        1'b1 |=> (chan_trig_o.load & ~$past(sync_config_i)) == 2'b00)
        else $error("load on unsynced channel");
    a_reg_lock: assert property (@(posedge core_clk_i) disable iff (rst_i) // RQ14
        (boot == RUN && in_en && !out_en && in_code == `IN_REG_LOCK && rise)
        |=> ##1 !reg_write_allowed_o) else $error("writes not locked");
    a_sw_masked: assert property (@(posedge core_clk_i) disable iff (rst_i) // RQ6
        (in_en && !out_en && in_code == `IN_PROTECT && !fall && boot == RUN)
        |=> !glob_trig_o.protect) else $error("software protect passed");
    a_oe_follow: assert property (@(posedge core_clk_i) disable iff (rst_i) // RQ2
        $rose(out_en) |=> !pin_oe_n_o) else $error("pin not driven");
    a_boot_once: assert property (@(posedge core_clk_i) disable iff (rst_i) // RQ4
        (boot == BOOT_FIRE) |=> (boot == RUN) [*2]) else $error("boot repeated");
endmodule : gpio_function_mapper
`default_nettype wire

/* verif/board_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// board logic on the far side of the general-purpose pin
module board_pin_model (
    input  wire logic want_lvl_i,   // level the board wants to drive
    input  wire logic attached_i,   // board driver connected to the pin
    input  wire logic dev_drive_i,  // device pin drive
    input  wire logic dev_oe_n_i,   // device drive enable, low while driving
    output logic      pin_lvl_o     // resolved wire level fed back to the device
);
    // the device drive wins; a detached board leaves only the pull-up tie,
    // so the pin never floats to a value the simulator picks
    always_comb begin
        if (!dev_oe_n_i) begin
            pin_lvl_o = dev_drive_i;
        end else if (attached_i) begin
            pin_lvl_o = want_lvl_i;
        end else begin
            pin_lvl_o = 1'b1;
        end
    end
endmodule : board_pin_model
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gpio_map_consts.svh"
module tb;
    import gpio_map_pkg::*;
    logic        core_clk_i = 1'b0;             // 100 MHz core clock
    logic        rst_i      = 1'b1;             // async reset
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0; // wishbone request
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic        ack, pin_lvl, pin_o, oe_n;     // bus answer and pin wires
    logic        want = 1'b1;                   // board level, idles high
    logic [1:0]  sync_cfg = 2'h0;               // per-channel sync update
    logic        regw = 1'b0, exempt = 1'b0;    // core write attempts
    status_s     st = '0;                       // converter status levels
    chan_trig_s  ct;
    glob_trig_s  gt;
    logic        nvm_ok, wr_ok, wr_rej, irq;
    logic [21:0] acc = '0;                      // sticky trigger pulses
    logic        acc_r = 1'b0;                  // sticky reject pulse
    int          err_total = 0;
    int          checks_done = 0;

    always #5 core_clk_i = ~core_clk_i;

    gpio_function_mapper gpio_function_mapper_i (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(pin_lvl), .pin_o(pin_o),
        .pin_oe_n_o(oe_n), .sync_config_i(sync_cfg), .reg_write_i(regw),
        .reg_write_exempt_i(exempt), .status_i(st), .chan_trig_o(ct),
        .glob_trig_o(gt), .nvm_prog_allowed_o(nvm_ok),
        .reg_write_allowed_o(wr_ok), .reg_write_reject_o(wr_rej), .irq_o(irq));

    board_pin_model board_pin_model_i (
        .want_lvl_i(want), .attached_i(1'b1), .dev_drive_i(pin_o),
        .dev_oe_n_i(oe_n), .pin_lvl_o(pin_lvl));

    // one-cycle pulses are easy to miss, so gather them until cleared
    always @(posedge core_clk_i) begin
        acc   <= acc | {ct, gt};
        acc_r <= acc_r | wr_rej;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge core_clk_i);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            conclude();
        end
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask : wb

    task automatic cfg(input logic [3:0] code, input logic [1:0] s);
        logic [31:0] q;
        wb(`ADDR_PIN_CONFIG, 1'b1, 32'({2'h0, s, code, 1'b1}), q);
    endtask : cfg

    task automatic clr();
        @(negedge core_clk_i);
        acc   = '0;
        acc_r = 1'b0;
    endtask : clr

    // move the board level and leave room for sync and dispatch
    task automatic pin_to(input logic lvl);
        clr();
        @(posedge core_clk_i);
        want <= lvl;
        repeat (8) @(posedge core_clk_i);
    endtask : pin_to

    function automatic logic [31:0] trig();
        return 32'(acc);
    endfunction : trig

    // expected channel pulses: fall drives the down half, rise the up half
    function automatic logic [31:0] ech(input logic [3:0] c, input logic [1:0] s,
                                       input logic f);
        int sh;
        case (c)
            `IN_CURRENT_OUTPUT_PWR: sh = 18;
            `IN_VOLTAGE_OUTPUT_PWR: sh = 14;
            `IN_FUNC_GEN: sh = 8;
            default:      sh = 4;
        endcase
        return 32'({f ? s : 2'h0, f ? 2'h0 : s}) << sh;
    endfunction : ech

    task automatic t_chan();
        logic [3:0] codes [4] = '{`IN_CURRENT_OUTPUT_PWR, `IN_VOLTAGE_OUTPUT_PWR, `IN_FUNC_GEN, `IN_MARGIN};
        logic [1:0] s;
        for (int i = 0; i < 8; i++) begin
            s = 2'(i % 2 + 1);
            cfg(codes[i / 2], s);
            pin_to(1'b0);
            check("chan fall", trig(), ech(codes[i / 2], s, 1'b1));
            pin_to(1'b1);
            check("chan rise", trig(), ech(codes[i / 2], s, 1'b0));
        end
    endtask : t_chan

    task automatic t_glob();
        logic [3:0] codes [4] = '{`IN_FAULT_DUMP, `IN_PROTECT, `IN_CLEAR, `IN_RESET};
        logic [31:0] q;
        for (int i = 0; i < 4; i++) begin
            cfg(codes[i], 2'h3);
            pin_to(1'b0);
            q = trig();
            pin_to(1'b1);
            // a reset request is a whole low pulse, judged over both edges
            if (i == 3) q = q | trig();
            check("global fall", q, 32'h8 >> i);
            if (i < 3) check("global rise", trig(), 32'h0);
        end
    endtask : t_glob

    task automatic t_load_sw();
        logic [31:0] q;
        sync_cfg <= 2'h1;
        cfg(`IN_LOAD, 2'h3);
        pin_to(1'b0);
        check("load fall", trig(), 32'h1000);
        pin_to(1'b1);
        check("load rise", trig(), 32'h0);
        cfg(`IN_CLEAR, 2'h0);
        clr();
        wb(`ADDR_SW_TRIGGER, 1'b1, 32'h4, q);
        repeat (4) @(posedge core_clk_i);
        check("sw clear masked", trig(), 32'h0);
        clr();
        wb(`ADDR_SW_TRIGGER, 1'b1, 32'h1, q);
        repeat (4) @(posedge core_clk_i);
        check("sw fault", trig(), 32'h8);
    endtask : t_load_sw

    task automatic t_lock();
        cfg(`IN_NVM_LOCK, 2'h0);
        pin_to(1'b0);
        check("nvm permit", 32'(nvm_ok), 32'h1);
        pin_to(1'b1);
        check("nvm block", 32'(nvm_ok), 32'h0);
        cfg(`IN_REG_LOCK, 2'h0);
        pin_to(1'b0);
        pin_to(1'b1);
        check("writes blocked", 32'(wr_ok), 32'h0);
        for (int i = 0; i < 2; i++) begin
            clr();
            @(posedge core_clk_i);
            {regw, exempt} <= {1'b1, 1'(i)};
            @(posedge core_clk_i);
            regw <= 1'b0;
            repeat (3) @(posedge core_clk_i);
            check("write reject", 32'(acc_r), 32'(1 - i));
        end
        pin_to(1'b0);
        check("writes permit", 32'(wr_ok), 32'h1);
    endtask : t_lock

    task automatic t_irq_out();
        logic [3:0] codes [5] = '{`OUT_NONVOLATILE_BUSY_FLAG, `OUT_CH1_BUSY, `OUT_CH0_BUSY,
                                  `OUT_WIN_CMP1, `OUT_WIN_CMP0};
        logic [31:0] q;
        cfg(`IN_FAULT_DUMP, 2'h0);
        wb(`ADDR_IRQ_MASK, 1'b1, 32'h0, q);
        pin_to(1'b1);
        wb(`ADDR_IRQ_STATUS, 1'b1, 32'h7, q);
        pin_to(1'b0);
        wb(`ADDR_IRQ_STATUS, 1'b0, 32'h0, q);
        check("fall status", q & 32'h6, 32'h2);
        check("irq masked", 32'(irq), 32'h0);
        wb(`ADDR_IRQ_MASK, 1'b1, 32'h2, q);
        repeat (2) @(posedge core_clk_i);
        check("irq raised", 32'(irq), 32'h1);
        wb(`ADDR_IRQ_STATUS, 1'b1, 32'h2, q);
        repeat (2) @(posedge core_clk_i);
        check("irq cleared", 32'(irq), 32'h0);
        // each status selected alone, then with every other source set
        for (int i = 0; i < 5; i++) begin
            wb(`ADDR_PIN_CONFIG, 1'b1, 32'({1'b1, codes[i], 9'h0}), q);
            st <= status_s'(5'h10 >> i);
            repeat (3) @(posedge core_clk_i);
            check("status high", 32'({oe_n, pin_o}), 32'h1);
            st <= status_s'(~(5'h10 >> i));
            repeat (3) @(posedge core_clk_i);
            check("status low", 32'({oe_n, pin_o}), 32'h0);
        end
    endtask : t_irq_out

    initial begin
        logic [31:0] q;
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        wb(`ADDR_PIN_CONFIG, 1'b0, 32'h0, q);
        check("config reset", q, 32'h0);
        check("pin released", 32'({oe_n, pin_o, wr_ok}), 32'h5);
        wb(8'h20, 1'b0, 32'h0, q);
        check("unmapped read", q, 32'h0);
        wb(`ADDR_IRQ_STATUS, 1'b0, 32'h0, q);
        check("boot status", q, 32'h1);
        wb(`ADDR_PIN_STATE, 1'b0, 32'h0, q);
        check("pin state", q, 32'h5);
        pin_to(1'b0);
        pin_to(1'b1);
        check("idle pin", trig(), 32'h0);
        t_chan();
        t_glob();
        t_load_sw();
        t_lock();
        t_irq_out();
        conclude();
    end
endmodule : tb
`default_nettype wire
